// [field_region_sequence_select.sv]
// Per-field region sequence select register set with AXI4-Lite access
// Summary of operation
// - Each of nine regions applies the sequence picked by its packed 5-bit select.
// - Repeat mode decodes: 0 none, 1 sweep, 2 multiplier, 3 both.
// - Regions 3 to 8 have own 2-bit repeat modes beside last-line length.
// - A 13-bit programmed value sets the final line length of each field.
// - With 14-bit horizontal counter enabled, bit 25 becomes length bit 13.
// - Region boundaries come from 13-bit positions, two per word, low and high; the last word holds one, low.
// - Up to change position eight is held, giving at most nine regions.
`include "field_region_defines.svh"

module field_region_sequence_select
  import field_region_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        vertical_sync_pulse,
  input  wire logic [12:0] line_count,
  output logic [4:0]       active_vseq_select,
  output logic             multiplier_enable,
  output logic             sweep_enable,
  output logic [13:0]      final_line_length,
  output region_index_t    active_region
);

  // --------------------------------------------------------------------------
  // Write channel capture
  // --------------------------------------------------------------------------
  logic          aw_held_q;
  logic [3:0]    aw_index_q;
  logic          w_held_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  reg_word_t     regs_q [0:8];
  reg_word_t     act_q  [0:8];

  wire do_write   = aw_held_q && w_held_q && !bvalid_q;
  wire wr_mapped  = aw_index_q <= `IDX_FIELD_CONTROL;
  wire [25:0] byte_mask = {{2{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q  <= 1'b0;
      aw_index_q <= 4'h0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q  <= 1'b1;
      aw_index_q <= s_axi_awaddr[5:2];
    end else if (do_write) begin
      aw_held_q  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register file and vertical sync shadow
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 9; i++) begin
        regs_q[i] <= `REG_RESET_VALUE;
      end
    end else if (do_write && wr_mapped) begin
      regs_q[aw_index_q] <= (regs_q[aw_index_q] & ~byte_mask)
                            | (w_data_q[25:0] & byte_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 9; i++) begin
        act_q[i] <= `REG_RESET_VALUE;
      end
    end else if (vertical_sync_pulse) begin
      for (int i = 0; i < 9; i++) begin
        act_q[i] <= regs_q[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Field decode of the active settings
  // --------------------------------------------------------------------------
  logic [4:0]  seq_sel  [0:8];
  logic [1:0]  mode_sel [0:8];
  logic [12:0] position [0:8];

  always_comb begin
    for (int k = 0; k < `SEQ_PER_WORD; k++) begin
      seq_sel[k] = act_q[`IDX_REGION_SEQUENCE_SELECT_LOW][k*5 +: 5];
    end
    for (int k = 0; k < 4; k++) begin
      seq_sel[k+5] = act_q[`IDX_REGION_SEQUENCE_SELECT_HIGH][k*5 +: 5];
    end
    for (int k = 0; k < 3; k++) begin
      mode_sel[k] = act_q[`IDX_REGION_SEQUENCE_SELECT_HIGH][`LOW_WORD_MODE_LSB + k*2 +: 2];
    end
    for (int k = 0; k < 6; k++) begin
      mode_sel[k+3] = act_q[`IDX_LAST_LINE_LENGTH_AND_MODES][`LAST_LEN_MODE_LSB + k*2 +: 2];
    end
    for (int k = 0; k < 9; k++) begin
      position[k] = k[0] ? act_q[`IDX_REGION_CHANGE_POSITION_PAIR0 + k/2][25:13]
                         : act_q[`IDX_REGION_CHANGE_POSITION_PAIR0 + k/2][12:0];
    end
  end

  // Region is the highest boundary already reached in the field
  region_index_t region_d;
  always_comb begin
    region_d = 4'h0;
    for (int k = 1; k < 9; k++) begin
      if (line_count >= position[k]) begin
        region_d = 4'(k);
      end
    end
  end

  repeat_mode_e mode_d;
  assign mode_d = repeat_mode_e'(mode_sel[region_d]);

  wire        hcount14_on = act_q[`IDX_FIELD_CONTROL][`CTRL_HCOUNT14_BIT];
  wire [25:0] len_word   = act_q[`IDX_LAST_LINE_LENGTH_AND_MODES];
  wire [13:0] last_len_d = {hcount14_on & len_word[`LAST_LEN_MSB_BIT],
                            len_word[12:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_vseq_select <= 5'h00;
      multiplier_enable  <= 1'b0;
      sweep_enable       <= 1'b0;
      final_line_length  <= 14'h0000;
      active_region      <= 4'h0;
    end else begin
      active_vseq_select <= seq_sel[region_d];
      multiplier_enable  <= (mode_d == mode_mult_only) || (mode_d == mode_mult_sweep);
      sweep_enable       <= (mode_d == mode_sweep_only) || (mode_d == mode_mult_sweep);
      final_line_length  <= last_len_d;
      active_region      <= region_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire [3:0] rd_index   = s_axi_araddr[5:2];
  wire       rd_status  = rd_index == `IDX_FIELD_STATUS;
  wire       rd_mapped  = rd_index <= `IDX_FIELD_STATUS;
  wire [31:0] rd_word   = rd_status ? {28'h0000000, active_region}
                        : rd_mapped ? {6'h00, regs_q[rd_index]} : 32'h00000000;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // field_region_sequence_select

// [field_region_defines.svh]
// Register offsets, field positions and reset values of the field region register set
`ifndef FIELD_REGION_DEFINES_SVH
`define FIELD_REGION_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_REGION_SEQUENCE_SELECT_LOW  4'h0
`define IDX_REGION_SEQUENCE_SELECT_HIGH 4'h1
`define IDX_LAST_LINE_LENGTH_AND_MODES  4'h2
`define IDX_REGION_CHANGE_POSITION_PAIR0 4'h3
`define IDX_REGION_CHANGE_POSITION_PAIR1 4'h4
`define IDX_REGION_CHANGE_POSITION_PAIR2 4'h5
`define IDX_REGION_CHANGE_POSITION_PAIR3 4'h6
`define IDX_REGION_CHANGE_POSITION_LAST  4'h7
`define IDX_FIELD_CONTROL               4'h8
`define IDX_FIELD_STATUS                4'h9
`define NUM_WRITABLE_REGS               10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SEQ_SELECT_WIDTH   5
`define SEQ_PER_WORD       5
`define MODE_WIDTH         2
`define LOW_WORD_MODE_LSB  20
`define LAST_LEN_WIDTH     13
`define LAST_LEN_MODE_LSB  13
`define LAST_LEN_MSB_BIT   25
`define POSITION_WIDTH     13
`define POSITION_HIGH_LSB  13
`define CTRL_HCOUNT14_BIT  0

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define REG_RESET_VALUE    26'h0000000
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// [field_region_pkg.sv]
// Types shared by the field region register set
package field_region_pkg;

  typedef logic [25:0] reg_word_t;
  typedef logic [3:0]  region_index_t;

  typedef enum logic [1:0] {
    mode_plain,
    mode_sweep_only,
    mode_mult_only,
    mode_mult_sweep
  } repeat_mode_e;

endpackage

// [field_region_sequence_select_properties.sv]
// Port checks of the field region register set
module field_region_sequence_select_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        vertical_sync_pulse,
  input wire logic [13:0] final_line_length,
  input wire logic [3:0]  active_region
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  write_done_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  read_done_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  word_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:26] == 6'h00)
    else $error("upper bits set");
  region_max_a: assert property (active_region <= 4'h8) else $error("region over 8");
  len_sync_a: assert property ($changed(final_line_length)
    |-> $past(vertical_sync_pulse, 2)) else $error("length moved off sync");
  c_region8: cover property (active_region == 4'h8);
  c_len_new: cover property (vertical_sync_pulse ##2 $changed(final_line_length));
  c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // field_region_sequence_select_properties

bind field_region_sequence_select field_region_sequence_select_properties u_props (.*);

// [field_region_sequence_select_tb.sv]
// Self-checking bench of the field region register set
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module field_region_sequence_select_tb
  import field_region_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          aclk = 1'b0, aresetn = 1'b0, vertical_sync_pulse = 1'b0;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sweep_enable;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic          s_axi_rvalid, multiplier_enable;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [3:0]    s_axi_wstrb = 4'hF, strb = 4'hF;
  logic [4:0]    active_vseq_select;
  logic [5:0]    s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [12:0]   line_count = 13'h0000;
  logic [13:0]   final_line_length;
  logic [25:0]   m [10], a [10];
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
  region_index_t active_region;
  int            n_errors = 0, checks = 0, seed = 41;

  field_region_sequence_select u_dut (.*);
  initial forever #2 aclk = ~aclk;
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    final_report();
  end

  // -------------------------------------------------------------------
  // One bus access, write when w is set; d is write data or read expect
  // -------------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d,
                     input logic [1:0] er);
    logic [25:0] mk;
    mk = {{2{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    if (w && i < 4'h9) m[i] = (m[i] & ~mk) | (d[25:0] & mk);
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid}
             <= {i, 2'h0, d, strb, 2'h3};
    else {s_axi_araddr, s_axi_arvalid} <= {i, 2'h0, 1'b1};
    do @(negedge aclk); while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready));
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(negedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    if (w) `CHK(s_axi_bresp, er)
    else `CHK({s_axi_rresp, s_axi_rdata}, {er, d})
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= {w, !w};
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask

  task automatic sweep();
    int r;
    logic [1:0] md;
    for (int lc = 0; lc < 170; lc++) begin
      @(posedge aclk);
      line_count <= 13'(lc);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      r = 0;
      for (int k = 1; k < 9; k++) begin
        if (lc >= (k % 2 ? a[3 + k / 2][25:13] : a[3 + k / 2][12:0])) r = k;
      end
      md = r < 3 ? a[1][20 + 2 * r +: 2] : a[2][7 + 2 * r +: 2];
      `CHK(active_region, 4'(r))
      `CHK(active_vseq_select, r < 5 ? a[0][5 * r +: 5] : a[1][5 * r - 25 +: 5])
      `CHK({multiplier_enable, sweep_enable}, md)
      `CHK(final_line_length, {a[8][0] & a[2][25], a[2][12:0]})
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    foreach (m[i]) m[i] = 26'h0;
    a = m;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // All boundaries at zero put line 0 in the last region
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 4'(i), {28'h0, (i == 9) ? 4'h8 : 4'h0}, 2'h0);
    end
    $display("reset values done");
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 3; i++) begin
        strb = 4'($random(seed));
        bus(1'b1, 4'(i), $random(seed), 2'h0);
      end
      strb = 4'hF;
      for (int i = 3; i < 8; i++) begin
        bus(1'b1, 4'(i), {6'h00, (i < 7 ? 13'(40 * i - 100 + p) : 13'h0000),
            13'(40 * i - 120 + p)}, 2'h0);
      end
      bus(1'b1, 4'h8, 32'(p % 2), 2'h0);
      for (int i = 0; i < 9; i++) bus(1'b0, 4'(i), {6'h00, m[i]}, 2'h0);
      bus(1'b1, 4'(9 + p), $random(seed), 2'h2);
      bus(1'b0, 4'(12 + p), 32'h0, 2'h2);
      sweep();
      @(posedge aclk);
      vertical_sync_pulse <= 1'b1;
      @(posedge aclk);
      vertical_sync_pulse <= 1'b0;
      a = m;
      sweep();
      $display("field pass %0d done", p);
    end
    final_report();
  end
endmodule // field_region_sequence_select_tb
